// ==== verilog/csr_params.svh ====
// csr_params.svh: numbers, masks and reset values of the CPU system register bank
// Assumes inclusion by bare name from every file that decodes register numbers.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// System register numbers
`define CSR_NUM_XPC     5'h00
`define CSR_NUM_XST     5'h01
`define CSR_NUM_NPC     5'h02
`define CSR_NUM_NST     5'h03
`define CSR_NUM_CODE    5'h04
`define CSR_NUM_PSW     5'h05
`define CSR_NUM_CALLTABLE_SAVED_PC    5'h10
`define CSR_NUM_CTST    5'h11
`define CSR_NUM_DEBUG_SAVED_PC    5'h12
`define CSR_NUM_DBST    5'h13
`define CSR_NUM_CTBASE  5'h14

// Field masks: counter keeps 26 bits, status keeps 8
`define CSR_PC_MASK     32'h03FF_FFFE
`define CSR_SPC_MASK    32'h03FF_FFFF
`define CSR_PSW_MASK    32'h0000_00FF

// Status flag positions used on entry and return
`define CSR_PSW_ID      32'h0000_0020
`define CSR_PSW_NP      32'h0000_0080
`define CSR_PSW_NP_BIT  7

// Reset values
`define CSR_PC_RST      32'h0000_0000
`define CSR_PSW_RST     32'h0000_0020
`define CSR_REG_RST     32'h0000_0000

`endif

// ==== verilog/csr_pkg.sv ====
// csr_pkg.sv: types shared by the system register bank files
// Assumes csr_params.svh carries the numeric constants.
`default_nettype none

package csr_pkg;
  // Register number as carried by load and store instructions
  typedef logic [4:0] csr_num_t;
  // Full register word
  typedef logic [31:0] csr_word_t;
  // Debug window state
  typedef enum logic
  {
    CSR_MODE_RUN = 1'b0,
    CSR_MODE_DEBUG = 1'b1
  } csr_mode_t;
endpackage

`default_nettype wire

// ==== verilog/csr_pc_next.sv ====
// csr_pc_next.sv: next program counter value, combinational
// Assumes the caller registers the result; priority restore, jump, add.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_pc_next
(
  // Current counter
  input wire csr_pkg::csr_word_t pc_i,
  // Relative advance
  input wire logic add_i,
  input wire csr_pkg::csr_word_t offset_i,
  // Absolute jump
  input wire logic jump_i,
  input wire csr_pkg::csr_word_t target_i,
  // Return from a saved pair
  input wire logic restore_i,
  input wire csr_pkg::csr_word_t restore_val_i,
  // Result
  output logic [31:0] next_pc_o
);
  import csr_pkg::*;

  logic [25:0] sum;
  csr_word_t raw;

  // Add in 26 bits, so a carry out of bit 25 is simply lost
  assign sum = pc_i[25:0] + offset_i[25:0]; // see RULE_02

  // Source selection
  assign raw = restore_i ? restore_val_i
             : jump_i ? target_i
             : add_i ? {6'h00, sum}
             : pc_i;

  // Top six bits and bit 0 forced low on every path
  assign next_pc_o = raw & `CSR_PC_MASK; // see RULE_01 see RULE_03 see RULE_14
endmodule // csr_pc_next

`default_nettype wire

// ==== verilog/csr_regfile.sv ====
// csr_regfile.sv: program counter and system register bank of the CPU
// Assumes the pipeline drives every request on ref_clk_i and supplies the
// resume address; interrupt logic presents one entry pulse per event.
// Function
// RULE_01: Counter keeps 26 bits, upper bits zero
// RULE_02: Carry out of bit 25 is dropped
// RULE_03: Counter bit 0 always zero
// RULE_04: Load and store select register by number
// RULE_05: Software avoids numbers 6-15 and 21-31
// RULE_06: Exception code register ignores loads
// RULE_07: Debug pair usable only inside debug window
// RULE_08: Exception entry saves counter and status
// RULE_09: Saved counter is next instruction address
// RULE_10: NMI entry saves into NMI pair only
// RULE_11: Saved pairs keep upper bits zero
// RULE_12: Return after exception restores exception pair
// RULE_13: Return after NMI restores NMI pair
// RULE_14: Saved counter bit 0 ignored on return
// RULE_15: Software writes even saved counter values
// RULE_16: Entry loads source code into code register
// RULE_17: Nesting handlers save pairs themselves
// RULE_18: Status load effective next cycle, upper zero
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_regfile
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Counter control from the pipeline
  input wire logic pc_add_i,
  input wire csr_pkg::csr_word_t pc_offset_i,
  input wire logic pc_jump_i,
  input wire csr_pkg::csr_word_t pc_target_i,
  // System register load instruction
  input wire logic ld_en_i,
  input wire csr_pkg::csr_num_t ld_num_i,
  input wire csr_pkg::csr_word_t ld_data_i,
  // System register store instruction
  input wire logic st_en_i,
  input wire csr_pkg::csr_num_t st_num_i,
  output logic [31:0] st_data_o,
  output logic st_valid_o,
  // Status flags written back by execution
  input wire logic status_wr_i,
  input wire csr_pkg::csr_word_t status_in_i,
  // Exception and interrupt entry
  input wire logic exc_take_i,
  input wire logic nmi_take_i,
  input wire csr_pkg::csr_word_t entry_code_i,
  input wire csr_pkg::csr_word_t resume_pc_i,
  // Return and debug window
  input wire logic interrupt_return_instr_i,
  input wire logic dbg_enter_i,
  input wire logic dbg_ret_i,
  // State seen by the pipeline
  output logic [31:0] pc_o,
  output logic [31:0] status_o,
  output logic [31:0] calltable_base_o,
  output logic dbg_active_o
);
  import csr_pkg::*;

  // Reset release synchroniser
  logic [1:0] rst_sync;
  logic rst_n;

  // Register bank, then next values
  csr_word_t pc, status, exc_saved_pc, exc_saved_st, nmi_saved_pc, nmi_saved_st, exception_code;
  csr_word_t ct_saved_pc, ct_saved_st, dbg_saved_pc, dbg_saved_st, calltable_base;
  csr_mode_t mode, next_mode;
  csr_word_t next_pc, next_status, next_exc_saved_pc, next_exc_saved_st, next_nmi_saved_pc, next_nmi_saved_st;
  csr_word_t next_exception_code, next_ct_saved_pc, next_ct_saved_st, next_dbg_saved_pc, next_dbg_saved_st;
  csr_word_t next_calltable_base;

  // Decode
  logic nmi_go, exc_go, entry, interrupt_return_instr_go, ret_nmi, ld_ok, dbg_ok;
  logic ld_xpc, ld_xst, ld_npc, ld_nst, ld_psw, ld_calltable_saved_pc, ld_ctst, ld_debug_saved_pc, ld_dbst, ld_ctbase;
  csr_word_t ret_pc, ret_st, st_val;

  // Deassertion synchronised, assertion immediate
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Entry priority: NMI over exception; both override a return
  assign nmi_go = nmi_take_i;
  assign exc_go = exc_take_i & ~nmi_take_i;
  assign entry = nmi_go | exc_go;
  assign interrupt_return_instr_go = interrupt_return_instr_i & ~entry;
  // In-service NMI flag picks the pair to restore
  assign ret_nmi = status[`CSR_PSW_NP_BIT];
  assign ret_pc = ret_nmi ? nmi_saved_pc : exc_saved_pc; // see RULE_12 see RULE_13
  assign ret_st = ret_nmi ? nmi_saved_st : exc_saved_st; // see RULE_12 see RULE_13

  // Loads lose to hardware saves in the same cycle
  assign ld_ok = ld_en_i & ~entry & ~interrupt_return_instr_go;
  assign dbg_ok = (mode == CSR_MODE_DEBUG);
  assign ld_xpc = ld_ok && ld_num_i == `CSR_NUM_XPC; // see RULE_04
  assign ld_xst = ld_ok && ld_num_i == `CSR_NUM_XST;
  assign ld_npc = ld_ok && ld_num_i == `CSR_NUM_NPC;
  assign ld_nst = ld_ok && ld_num_i == `CSR_NUM_NST;
  assign ld_psw = ld_ok && ld_num_i == `CSR_NUM_PSW;
  assign ld_calltable_saved_pc = ld_ok && ld_num_i == `CSR_NUM_CALLTABLE_SAVED_PC;
  assign ld_ctst = ld_ok && ld_num_i == `CSR_NUM_CTST;
  assign ld_debug_saved_pc = ld_ok && dbg_ok && ld_num_i == `CSR_NUM_DEBUG_SAVED_PC; // see RULE_07
  assign ld_dbst = ld_ok && dbg_ok && ld_num_i == `CSR_NUM_DBST; // see RULE_07
  assign ld_ctbase = ld_ok && ld_num_i == `CSR_NUM_CTBASE;

  // Counter path; restore ignores saved bit 0
  csr_pc_next u_pc_next
  (
    .pc_i(pc),
    .add_i(pc_add_i),
    .offset_i(pc_offset_i),
    .jump_i(pc_jump_i),
    .target_i(pc_target_i),
    .restore_i(interrupt_return_instr_go),
    .restore_val_i(ret_pc),
    .next_pc_o(next_pc)
  );

  // Saved pairs: pipeline resume address is the following instruction
  assign next_exc_saved_pc = exc_go ? (resume_pc_i & `CSR_SPC_MASK) // see RULE_08 see RULE_09
                           : ld_xpc ? (ld_data_i & `CSR_SPC_MASK) : exc_saved_pc; // see RULE_11
  assign next_exc_saved_st = exc_go ? status // see RULE_08
                           : ld_xst ? (ld_data_i & `CSR_PSW_MASK) : exc_saved_st; // see RULE_11
  assign next_nmi_saved_pc = nmi_go ? (resume_pc_i & `CSR_SPC_MASK) // see RULE_10 see RULE_09
                           : ld_npc ? (ld_data_i & `CSR_SPC_MASK) : nmi_saved_pc; // see RULE_11
  assign next_nmi_saved_st = nmi_go ? status // see RULE_10
                           : ld_nst ? (ld_data_i & `CSR_PSW_MASK) : nmi_saved_st; // see RULE_11

  // Code register has no load path at all
  assign next_exception_code = entry ? entry_code_i : exception_code; // see RULE_16 see RULE_06

  // Status: entry masks interrupts, return restores, load then flags
  assign next_status = nmi_go ? (status | `CSR_PSW_NP | `CSR_PSW_ID)
                     : exc_go ? (status | `CSR_PSW_ID)
                     : interrupt_return_instr_go ? ret_st
                     : ld_psw ? (ld_data_i & `CSR_PSW_MASK) // see RULE_18
                     : status_wr_i ? (status_in_i & `CSR_PSW_MASK)
                     : status;

  // Call-table and debug registers, software loads only
  assign next_ct_saved_pc = ld_calltable_saved_pc ? (ld_data_i & `CSR_SPC_MASK) : ct_saved_pc;
  assign next_ct_saved_st = ld_ctst ? (ld_data_i & `CSR_PSW_MASK) : ct_saved_st;
  assign next_dbg_saved_pc = ld_debug_saved_pc ? (ld_data_i & `CSR_SPC_MASK) : dbg_saved_pc;
  assign next_dbg_saved_st = ld_dbst ? (ld_data_i & `CSR_PSW_MASK) : dbg_saved_st;
  assign next_calltable_base = ld_ctbase ? ld_data_i : calltable_base;

  // Debug window state machine
  always_comb
  begin
    case (mode)
      CSR_MODE_RUN: next_mode = dbg_enter_i ? CSR_MODE_DEBUG : CSR_MODE_RUN;
      CSR_MODE_DEBUG: next_mode = dbg_ret_i ? CSR_MODE_RUN : CSR_MODE_DEBUG;
      default: next_mode = CSR_MODE_RUN;
    endcase
  end

  // Store read mux; reserved and closed debug numbers read zero
  assign st_val = (st_num_i == `CSR_NUM_XPC) ? exc_saved_pc // see RULE_04
                : (st_num_i == `CSR_NUM_XST) ? exc_saved_st
                : (st_num_i == `CSR_NUM_NPC) ? nmi_saved_pc
                : (st_num_i == `CSR_NUM_NST) ? nmi_saved_st
                : (st_num_i == `CSR_NUM_CODE) ? exception_code
                : (st_num_i == `CSR_NUM_PSW) ? status
                : (st_num_i == `CSR_NUM_CALLTABLE_SAVED_PC) ? ct_saved_pc
                : (st_num_i == `CSR_NUM_CTST) ? ct_saved_st
                : (st_num_i == `CSR_NUM_DEBUG_SAVED_PC && dbg_ok) ? dbg_saved_pc // see RULE_07
                : (st_num_i == `CSR_NUM_DBST && dbg_ok) ? dbg_saved_st
                : (st_num_i == `CSR_NUM_CTBASE) ? calltable_base
                : `CSR_REG_RST;

  // Counter, status and mode
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= `CSR_PC_RST;
      status <= `CSR_PSW_RST;
      mode <= CSR_MODE_RUN;
    end
    else
    begin
      pc <= next_pc;
      status <= next_status;
      mode <= next_mode;
    end
  end

  // Saved pairs, code, call-table and debug registers
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exc_saved_pc <= `CSR_REG_RST;
      exc_saved_st <= `CSR_REG_RST;
      nmi_saved_pc <= `CSR_REG_RST;
      nmi_saved_st <= `CSR_REG_RST;
      exception_code <= `CSR_REG_RST;
      ct_saved_pc <= `CSR_REG_RST;
      ct_saved_st <= `CSR_REG_RST;
      dbg_saved_pc <= `CSR_REG_RST;
      dbg_saved_st <= `CSR_REG_RST;
      calltable_base <= `CSR_REG_RST;
    end
    else
    begin
      exc_saved_pc <= next_exc_saved_pc;
      exc_saved_st <= next_exc_saved_st;
      nmi_saved_pc <= next_nmi_saved_pc;
      nmi_saved_st <= next_nmi_saved_st;
      exception_code <= next_exception_code;
      ct_saved_pc <= next_ct_saved_pc;
      ct_saved_st <= next_ct_saved_st;
      dbg_saved_pc <= next_dbg_saved_pc;
      dbg_saved_st <= next_dbg_saved_st;
      calltable_base <= next_calltable_base;
    end
  end

  // Store answer registered, one cycle after the request
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_data_o <= `CSR_REG_RST;
      st_valid_o <= 1'b0;
    end
    else
    begin
      st_data_o <= st_val;
      st_valid_o <= st_en_i;
    end
  end

  // Outputs straight from the bank flops
  assign pc_o = pc;
  assign status_o = status;
  assign calltable_base_o = calltable_base;
  assign dbg_active_o = (mode == CSR_MODE_DEBUG);

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_pc_shape;
    pc[31:26] == 6'h00 && pc[0] == 1'b0;
  endproperty
  a_pc_shape: assert property (p_pc_shape) // see RULE_01 see RULE_03
    else $error("counter upper bits or bit 0 set");

  property p_pc_wrap;
    pc_add_i && !pc_jump_i && !interrupt_return_instr_go |=>
      pc == (($past(pc) + $past(pc_offset_i)) & `CSR_PC_MASK);
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) // see RULE_02
    else $error("counter add did not drop carry");

  property p_exc_save;
    exc_take_i && !nmi_take_i |=> exc_saved_pc == ($past(resume_pc_i) & `CSR_SPC_MASK)
      && exc_saved_st == $past(status) && status[5];
  endproperty
  a_exc_save: assert property (p_exc_save) // see RULE_08
    else $error("exception entry save wrong");

  property p_nmi_save;
    nmi_take_i |=> nmi_saved_pc == ($past(resume_pc_i) & `CSR_SPC_MASK)
      && nmi_saved_st == $past(status) && $stable(exc_saved_pc) && $stable(exc_saved_st);
  endproperty
  a_nmi_save: assert property (p_nmi_save) // see RULE_10
    else $error("nmi entry save wrong");

  property p_save_upper;
    exc_saved_pc[31:26] == 6'h00 && nmi_saved_pc[31:26] == 6'h00
      && exc_saved_st[31:8] == 24'h00_0000 && nmi_saved_st[31:8] == 24'h00_0000;
  endproperty
  a_save_upper: assert property (p_save_upper) // see RULE_11
    else $error("saved pair upper bits set");

  property p_interrupt_return_instr_exc;
    interrupt_return_instr_i && !entry && !status[7] |=>
      pc == ($past(exc_saved_pc) & `CSR_PC_MASK) && status == $past(exc_saved_st);
  endproperty
  a_interrupt_return_instr_exc: assert property (p_interrupt_return_instr_exc) // see RULE_12
    else $error("return from exception restore wrong");

  property p_interrupt_return_instr_nmi;
    interrupt_return_instr_i && !entry && status[7] |=>
      pc == ($past(nmi_saved_pc) & `CSR_PC_MASK) && status == $past(nmi_saved_st);
  endproperty
  a_interrupt_return_instr_nmi: assert property (p_interrupt_return_instr_nmi) // see RULE_13
    else $error("return from nmi restore wrong");

  property p_code_ro;
    ld_en_i && ld_num_i == `CSR_NUM_CODE && !entry |=> $stable(exception_code);
  endproperty
  a_code_ro: assert property (p_code_ro) // see RULE_06
    else $error("code register changed by load");
  property p_code_load;
    entry |=> exception_code == $past(entry_code_i);
  endproperty
  a_code_load: assert property (p_code_load) // see RULE_16
    else $error("code register not loaded on entry");
  property p_dbg_gate;
    ld_en_i && ld_num_i == `CSR_NUM_DEBUG_SAVED_PC && mode == CSR_MODE_RUN |=> $stable(dbg_saved_pc);
  endproperty
  a_dbg_gate: assert property (p_dbg_gate) // see RULE_07
    else $error("debug pair loaded outside window");
  property p_psw_load;
    ld_en_i && ld_num_i == `CSR_NUM_PSW && !entry && !interrupt_return_instr_i |=>
      status == ($past(ld_data_i) & `CSR_PSW_MASK);
  endproperty
  a_psw_load: assert property (p_psw_load) // see RULE_18
    else $error("status load not effective");

  property p_store;
    st_en_i && st_num_i == `CSR_NUM_PSW |=> st_valid_o && st_data_o == $past(status);
  endproperty
  a_store: assert property (p_store) // see RULE_04
    else $error("store answer wrong");

  c_exc_ret: cover property (exc_go ##[1:40] interrupt_return_instr_i);
  c_nmi: cover property (nmi_go ##1 status[7]);
  c_dbg_load: cover property (dbg_enter_i ##[1:8] ld_debug_saved_pc);
endmodule // csr_regfile

`default_nettype wire

// ==== testbench/csr_pipe_model.sv ====
// csr_pipe_model.sv: pipeline and interrupt-acknowledge side facing the register bank
// Assumes one shared clock; requests start 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module csr_pipe_model
(
  // Clock
  input wire logic clk_i,
  // One strobe per request kind, shared number and words
  output var logic [9:0] strobe_o,
  output var csr_pkg::csr_num_t num_o,
  output var csr_pkg::csr_word_t word_a_o,
  output var csr_pkg::csr_word_t word_b_o,
  // Store answer
  input wire csr_pkg::csr_word_t st_data_i,
  input wire logic st_valid_i
);
  import csr_pkg::*;

  // Quiet lines at time zero
  initial
  begin
    strobe_o = '0;
    num_o = '0;
    word_a_o = '0;
    word_b_o = '0;
  end

  // One request held for one whole cycle, then released
  task automatic fire(input logic [9:0] s, input csr_num_t n, input csr_word_t a, input csr_word_t b);
    @(posedge clk_i);
    #1;
    strobe_o = s;
    num_o = n; // Callers pass documented numbers only
    word_a_o = a; // Saved counters get even values unless a test means otherwise
    word_b_o = b;
    @(posedge clk_i);
    #1;
    strobe_o = '0;
    // Released lines flip so stale data never passes for a fresh request
    num_o = ~num_o;
    word_a_o = ~word_a_o;
    word_b_o = ~word_b_o;
  endtask

  // Store answer stands only in the cycle after the request edge
  task automatic store(input csr_num_t n, output csr_word_t d, output logic v);
    fire(10'h008, n, 32'h0000_0000, 32'h0000_0000);
    d = st_data_i;
    v = st_valid_i;
  endtask
endmodule // csr_pipe_model

`default_nettype wire

// ==== testbench/csr_regfile_test.sv ====
// csr_regfile_test.sv: self-checking bench for the system register bank
// Assumes csr_pipe_model drives every pipeline input of the bank.
`timescale 1ns/1ps
`default_nettype none
`include "csr_params.svh"

module csr_regfile_test;
  import csr_pkg::*;

  // Strobe positions of the model's request vector
  localparam logic [9:0] S_ADD = 10'h001, S_JMP = 10'h002, S_LD = 10'h004, S_SWR = 10'h010;
  localparam logic [9:0] S_EXC = 10'h020, S_NMI = 10'h040, S_RET = 10'h080, S_DBE = 10'h100, S_DBR = 10'h200;

  logic ref_clk;
  logic rst_n;
  logic [9:0] stb;
  csr_num_t num;
  csr_word_t wa;
  csr_word_t wb;
  logic [31:0] st_data;
  logic [31:0] pc;
  logic [31:0] status;
  logic [31:0] ctb;
  logic st_valid;
  logic dbg_act;
  int n_fail;
  int compares;

  // Shared words: only one request kind is active per cycle
  csr_regfile dut
  (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .pc_add_i(stb[0]), .pc_offset_i(wa), .pc_jump_i(stb[1]),
    .pc_target_i(wa), .ld_en_i(stb[2]), .ld_num_i(num), .ld_data_i(wa), .st_en_i(stb[3]),
    .st_num_i(num), .st_data_o(st_data), .st_valid_o(st_valid), .status_wr_i(stb[4]),
    .status_in_i(wa), .exc_take_i(stb[5]), .nmi_take_i(stb[6]), .entry_code_i(wb),
    .resume_pc_i(wa), .interrupt_return_instr_i(stb[7]), .dbg_enter_i(stb[8]), .dbg_ret_i(stb[9]), .pc_o(pc),
    .status_o(status), .calltable_base_o(ctb), .dbg_active_o(dbg_act)
  );

  csr_pipe_model pm
  (
    .clk_i(ref_clk), .strobe_o(stb), .num_o(num), .word_a_o(wa), .word_b_o(wb),
    .st_data_i(st_data), .st_valid_i(st_valid)
  );

  // 200 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_st(input csr_num_t n, input csr_word_t exp);
    csr_word_t d;
    logic v;
    pm.store(n, d, v);
    chk("store valid", 32'h0000_0001, {31'h0, v});
    chk($sformatf("store of %0d", n), exp, d);
  endtask

  task automatic ld(input csr_num_t n, input csr_word_t d);
    pm.fire(S_LD, n, d, 32'h0000_0000);
  endtask

  task automatic ev(input logic [9:0] s, input csr_word_t a, input csr_word_t b);
    pm.fire(s, 5'h00, a, b);
  endtask

  // Values right after reset
  task automatic t_reset;
    chk("pc", `CSR_PC_RST, pc);
    chk("status", `CSR_PSW_RST, status);
    chk("dbg", 32'h0, {31'h0, dbg_act});
  endtask

  // Masking, bit 0 and carry out of bit 25
  task automatic t_pc;
    ev(S_JMP, 32'hFFFF_FFFF, 32'h0);
    chk("pc", 32'h03FF_FFFE, pc);
    ev(S_ADD, 32'h0000_0004, 32'h0);
    chk("pc", 32'h0000_0002, pc);
    ev(S_ADD, 32'h0000_0003, 32'h0);
    chk("pc", 32'h0000_0004, pc);
  endtask

  // All ones into every writable number but PSW and the debug pair; reserved upper bits come back zero
  task automatic t_regs;
    csr_num_t nums [7] = '{`CSR_NUM_XPC, `CSR_NUM_XST, `CSR_NUM_NPC, `CSR_NUM_NST,
                           `CSR_NUM_CALLTABLE_SAVED_PC, `CSR_NUM_CTST, `CSR_NUM_CTBASE};
    csr_word_t exps [7] = '{`CSR_SPC_MASK, `CSR_PSW_MASK, `CSR_SPC_MASK, `CSR_PSW_MASK,
                            `CSR_SPC_MASK, `CSR_PSW_MASK, 32'hFFFF_FFFF};
    foreach (nums[i])
      ld(nums[i], 32'hFFFF_FFFF);
    foreach (nums[i])
      chk_st(nums[i], exps[i]);
    chk("ctbase", 32'hFFFF_FFFF, ctb);
    ld(`CSR_NUM_PSW, 32'hFFFF_FF4C);
    chk("status", 32'h0000_004C, status);
    chk_st(`CSR_NUM_PSW, 32'h0000_004C);
    ev(S_SWR, 32'hFFFF_FF0F, 32'h0);
    chk("status", 32'h0000_000F, status);
  endtask

  // Exception entry, then a load aimed at the read-only code register
  task automatic t_exc;
    ev(S_EXC, 32'h0000_1234, 32'h0000_0050);
    chk("status", 32'h0000_002F, status);
    chk_st(`CSR_NUM_XPC, 32'h0000_1234);
    chk_st(`CSR_NUM_XST, 32'h0000_000F);
    chk_st(`CSR_NUM_CODE, 32'h0000_0050);
    ld(`CSR_NUM_CODE, 32'h0000_0077);
    chk_st(`CSR_NUM_CODE, 32'h0000_0050);
  endtask

  // Nested NMI inside the exception handler, then both returns
  task automatic t_nmi;
    ev(S_NMI, 32'h0000_2000, 32'h0000_0010);
    chk_st(`CSR_NUM_NPC, 32'h0000_2000);
    chk_st(`CSR_NUM_NST, 32'h0000_002F);
    chk_st(`CSR_NUM_XPC, 32'h0000_1234);
    chk_st(`CSR_NUM_CODE, 32'h0000_0010);
    ev(S_RET, 32'h0, 32'h0);
    chk("pc", 32'h0000_2000, pc);
    chk("status", 32'h0000_002F, status);
    ev(S_RET, 32'h0, 32'h0);
    chk("pc", 32'h0000_1234, pc);
    chk("status", 32'h0000_000F, status);
  endtask

  // Odd saved counters written on purpose; bit 0 dropped on return
  task automatic t_odd;
    ld(`CSR_NUM_XPC, 32'h0000_3457);
    chk_st(`CSR_NUM_XPC, 32'h0000_3457);
    ev(S_RET, 32'h0, 32'h0);
    chk("pc", 32'h0000_3456, pc);
    ld(`CSR_NUM_NPC, 32'h0000_5679);
    ld(`CSR_NUM_PSW, 32'h0000_0080);
    ev(S_RET, 32'h0, 32'h0);
    chk("pc", 32'h0000_5678, pc);
  endtask

  // Debug pair usable only inside the debug window
  task automatic t_dbg;
    ld(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0044);
    chk_st(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0000);
    ev(S_DBE, 32'h0, 32'h0);
    chk("dbg", 32'h1, {31'h0, dbg_act});
    chk_st(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0000);
    ld(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0044);
    ld(`CSR_NUM_DBST, 32'hFFFF_FF12);
    chk_st(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0044);
    chk_st(`CSR_NUM_DBST, 32'h0000_0012);
    ev(S_DBR, 32'h0, 32'h0);
    chk_st(`CSR_NUM_DEBUG_SAVED_PC, 32'h0000_0000);
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence; first request no earlier than the third edge after release
  initial
  begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset();
    t_pc();
    t_regs();
    t_exc();
    t_nmi();
    t_odd();
    t_dbg();
    end_of_test();
  end

  // Hang guard, far beyond the hundred or so cycles the run needs
  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule // csr_regfile_test

`default_nettype wire
